// ---- design/touch_sense_pkg.sv ----
// package: register map, field layout, reset values and constants of the touch sense core
package touch_sense_pkg;
  // byte addresses of the registers on the apb bus
  localparam logic [7:0] addr_osc_range_ctrl = 8'h00;
  localparam logic [7:0] addr_function_count_high = 8'h04;
  localparam logic [7:0] addr_function_count_low = 8'h08;
  localparam logic [7:0] addr_sense_count_high = 8'h0C;
  localparam logic [7:0] addr_sense_count_low = 8'h10;
  localparam logic [7:0] addr_ref_cap_trim_high = 8'h14;
  localparam logic [7:0] addr_ref_cap_trim_low = 8'h18;
  localparam logic [7:0] addr_sense_osc_ctrl = 8'h1C;
  localparam logic [7:0] addr_measure_ctrl = 8'h20;
  // field positions in measure_ctrl
  localparam int pos_div_sel = 0;
  localparam int pos_fc_ovf = 3;
  localparam int pos_sc_ovf = 4;
  localparam int pos_start = 5;
  localparam int pos_slot_ovf = 6;
  // field positions in sense_osc_ctrl
  localparam int pos_hop_code = 0;
  localparam int pos_hop_src = 3;
  localparam int pos_dbl_en = 5;
  localparam int pos_mux_sel = 6;
  // reset values and the prescaler top count
  localparam logic [1:0] rst_osc_range = 2'h3;
  localparam logic [15:0] rst_count = 16'h0000;
  localparam logic [9:0] rst_trim = 10'h000;
  localparam logic [7:0] rst_byte = 8'h00;
  localparam logic [2:0] div_count_max = 3'h7;

  // oscillator control bundle sent to the analogue side
  typedef struct packed {
    logic [1:0] range_sel;
    logic key_sel;
    logic dbl_en;
    logic hop_hw;
    logic [2:0] hop_code;
    logic [9:0] cap_trim;
    logic osc_en;
  } osc_ctrl_t;

  // measurement state
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_run = 2'b01,
    st_held = 2'b11
  } meas_state_t;
endpackage

// ---- design/touch_sense_count_regs.sv ----
// touch sense measurement core: counters, oscillator controls and apb register file
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module touch_sense_count_regs (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic sense_input_one_in,
  input wire logic sense_input_two_in,
  input wire logic slot_overflow_in,
  output touch_sense_pkg::osc_ctrl_t osc_ctrl_out,
  output logic touch_irq_request_out
);

  // ************************************************************
  // reset release and input synchronisers
  // ************************************************************
  logic rst_meta_q;
  logic rst_n_q;
  // async assert, sync release so no flop leaves reset on a ragged edge
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  logic [1:0] key_meta_q;
  logic [1:0] key_sync_q;
  logic key_last_q;
  logic slot_meta_q;
  logic slot_sync_q;
  logic slot_last_q;
  // oscillator pins are asynchronous: two flops before any use
  always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      key_meta_q <= 2'b00;
      key_sync_q <= 2'b00;
      slot_meta_q <= 1'b0;
      slot_sync_q <= 1'b0;
    end else begin
      key_meta_q <= {sense_input_two_in, sense_input_one_in};
      key_sync_q <= key_meta_q;
      slot_meta_q <= slot_overflow_in;
      slot_sync_q <= slot_meta_q;
    end
  end

  // ************************************************************
  // register state
  // ************************************************************
  logic [1:0] range_q;
  logic [9:0] trim_q;
  logic mux_sel_q;
  logic dbl_en_q;
  logic hop_src_q;
  logic [2:0] hop_code_q;
  logic start_q;
  logic [1:0] div_sel_q;
  logic slot_ovf_q;
  logic sc_ovf_q;
  logic fc_ovf_q;
  logic [15:0] fcount_q;
  logic [15:0] scount_q;
  logic [2:0] div_cnt_q;
  touch_sense_pkg::meas_state_t state_q;

  logic wr_en;
  logic sel_key;
  logic key_rise;
  logic slot_rise;
  logic fc_tick;
  logic running;
  logic [7:0] wbyte;

  // apb write strobe: taken in the access phase, zero-wait slave
  assign wr_en = psel_in & penable_in & pwrite_in;
  assign wbyte = pwdata_in[7:0];
  assign running = (state_q == touch_sense_pkg::st_run);
  // selected key after synchronisation
  assign sel_key = mux_sel_q ? key_sync_q[1] : key_sync_q[0];
  assign key_rise = sel_key & ~key_last_q;
  assign slot_rise = slot_sync_q & ~slot_last_q;

  // edge detector history, read only from synchronised copies
  always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      key_last_q <= 1'b0;
      slot_last_q <= 1'b0;
    end else begin
      key_last_q <= sel_key;
      slot_last_q <= slot_sync_q;
    end
  end

  // ************************************************************
  // software control registers
  // ************************************************************
  always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      range_q <= touch_sense_pkg::rst_osc_range;
      trim_q <= touch_sense_pkg::rst_trim;
      mux_sel_q <= 1'b0;
      dbl_en_q <= 1'b0;
      hop_src_q <= 1'b0;
      hop_code_q <= 3'h0;
      start_q <= 1'b0;
      div_sel_q <= 2'h0;
    end else if (wr_en) begin
      if (paddr_in == touch_sense_pkg::addr_osc_range_ctrl) begin
        range_q <= wbyte[1:0];
      end else if (paddr_in == touch_sense_pkg::addr_ref_cap_trim_high) begin
        trim_q[9:8] <= wbyte[1:0];
      end else if (paddr_in == touch_sense_pkg::addr_ref_cap_trim_low) begin
        trim_q[7:0] <= wbyte;
      end else if (paddr_in == touch_sense_pkg::addr_sense_osc_ctrl) begin
        mux_sel_q <= wbyte[touch_sense_pkg::pos_mux_sel];
        dbl_en_q <= wbyte[touch_sense_pkg::pos_dbl_en];
        hop_src_q <= wbyte[touch_sense_pkg::pos_hop_src];
        hop_code_q <= wbyte[touch_sense_pkg::pos_hop_code +: 3];
      end else if (paddr_in == touch_sense_pkg::addr_measure_ctrl) begin
        start_q <= wbyte[touch_sense_pkg::pos_start];
        div_sel_q <= wbyte[touch_sense_pkg::pos_div_sel +: 2];
      end
    end
  end

  // ************************************************************
  // measurement sequencing
  // ************************************************************
  // a second overflow cannot restart: only a 0 then 1 on start runs again
  always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= touch_sense_pkg::st_idle;
    end else if (!start_q) begin
      state_q <= touch_sense_pkg::st_idle;
    end else begin
      case (state_q)
        touch_sense_pkg::st_idle: begin
          state_q <= touch_sense_pkg::st_run;
        end
        touch_sense_pkg::st_run: begin
          if (slot_rise) begin
            state_q <= touch_sense_pkg::st_held;
          end
        end
        default: begin
          state_q <= touch_sense_pkg::st_held;
        end
      endcase
    end
  end

  // function counter prescaler, divider cleared whenever the state is not st_run
  always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      div_cnt_q <= 3'h0;
    end else if (!running) begin
      div_cnt_q <= 3'h0;
    end else begin
      div_cnt_q <= div_cnt_q + 3'h1;
    end
  end

  // tick once per 1, 2, 4 or 8 system clocks
  always_comb begin
    case (div_sel_q)
      2'h0: fc_tick = running;
      2'h1: fc_tick = running & (div_cnt_q[0] == 1'b1);
      2'h2: fc_tick = running & (div_cnt_q[1:0] == 2'h3);
      default: fc_tick = running & (div_cnt_q == touch_sense_pkg::div_count_max);
    endcase
  end

  // counters: cleared while start low, frozen once held
  always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fcount_q <= touch_sense_pkg::rst_count;
      scount_q <= touch_sense_pkg::rst_count;
    end else if (!start_q) begin
      fcount_q <= touch_sense_pkg::rst_count;
      scount_q <= touch_sense_pkg::rst_count;
    end else if (running && !slot_rise) begin
      if (fc_tick) begin
        fcount_q <= fcount_q + 16'h0001;
      end
      if (key_rise) begin
        scount_q <= scount_q + 16'h0001;
      end
    end
  end

  // ************************************************************
  // sticky flags: hardware set beats software clear
  // ************************************************************
  logic clr_flags;
  assign clr_flags = wr_en & (paddr_in == touch_sense_pkg::addr_measure_ctrl);
  always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      slot_ovf_q <= 1'b0;
      sc_ovf_q <= 1'b0;
      fc_ovf_q <= 1'b0;
    end else begin
      // software may only clear; writing 1 leaves the flag as it is
      if (running && slot_rise) begin
        slot_ovf_q <= 1'b1;
      end else if (clr_flags && !wbyte[touch_sense_pkg::pos_slot_ovf]) begin
        slot_ovf_q <= 1'b0;
      end
      if (running && !slot_rise && key_rise && (scount_q == 16'hFFFF)) begin
        sc_ovf_q <= 1'b1;
      end else if (clr_flags && !wbyte[touch_sense_pkg::pos_sc_ovf]) begin
        sc_ovf_q <= 1'b0;
      end
      if (running && !slot_rise && fc_tick && (fcount_q == 16'hFFFF)) begin
        fc_ovf_q <= 1'b1;
      end else if (clr_flags && !wbyte[touch_sense_pkg::pos_fc_ovf]) begin
        fc_ovf_q <= 1'b0;
      end
    end
  end

  // request pulse, one cycle, only from hardware overflow
  always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      touch_irq_request_out <= 1'b0;
    end else begin
      touch_irq_request_out <= running & slot_rise;
    end
  end

  // ************************************************************
  // oscillator control outputs
  // ************************************************************
  always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      osc_ctrl_out <= '0;
      osc_ctrl_out.range_sel <= touch_sense_pkg::rst_osc_range;
    end else begin
      osc_ctrl_out.range_sel <= range_q;
      osc_ctrl_out.key_sel <= mux_sel_q;
      osc_ctrl_out.dbl_en <= dbl_en_q;
      osc_ctrl_out.hop_hw <= hop_src_q;
      // software code masked while hardware hops
      osc_ctrl_out.hop_code <= hop_src_q ? 3'h0 : hop_code_q;
      osc_ctrl_out.cap_trim <= trim_q;
      osc_ctrl_out.osc_en <= running & ~slot_rise;
    end
  end

  // ************************************************************
  // apb read path
  // ************************************************************
  logic [7:0] rbyte;
  logic hit;
  always_comb begin
    rbyte = 8'h00;
    hit = 1'b1;
    if (paddr_in == touch_sense_pkg::addr_osc_range_ctrl) begin
      rbyte = {6'h00, range_q};
    end else if (paddr_in == touch_sense_pkg::addr_function_count_high) begin
      rbyte = fcount_q[15:8];
    end else if (paddr_in == touch_sense_pkg::addr_function_count_low) begin
      rbyte = fcount_q[7:0];
    end else if (paddr_in == touch_sense_pkg::addr_sense_count_high) begin
      rbyte = scount_q[15:8];
    end else if (paddr_in == touch_sense_pkg::addr_sense_count_low) begin
      rbyte = scount_q[7:0];
    end else if (paddr_in == touch_sense_pkg::addr_ref_cap_trim_high) begin
      rbyte = {6'h00, trim_q[9:8]};
    end else if (paddr_in == touch_sense_pkg::addr_ref_cap_trim_low) begin
      rbyte = trim_q[7:0];
    end else if (paddr_in == touch_sense_pkg::addr_sense_osc_ctrl) begin
      rbyte = {1'b0, mux_sel_q, dbl_en_q, 1'b0, hop_src_q, hop_code_q};
    end else if (paddr_in == touch_sense_pkg::addr_measure_ctrl) begin
      rbyte = {1'b0, slot_ovf_q, start_q, sc_ovf_q, fc_ovf_q, 1'b0, div_sel_q};
    end else begin
      hit = 1'b0;
    end
  end

  // registered answer: pready one cycle after the setup phase
  always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      prdata_out <= 32'h00000000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & ~hit;
      prdata_out <= (psel_in & ~penable_in & ~pwrite_in) ? {24'h000000, rbyte} : 32'h00000000;
    end
  end

endmodule

// ---- dv/touch_sense_count_regs_checker.sv ----
// checker: port assertions for the touch sense measurement core
`timescale 1ns/1ps
module touch_sense_count_regs_checker (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic sense_input_one_in,
  input wire logic sense_input_two_in,
  input wire logic slot_overflow_in,
  input wire touch_sense_pkg::osc_ctrl_t osc_ctrl_out,
  input wire logic touch_irq_request_out
);
  // ****************
  // clocking and bus steps
  // ****************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // completed write to one register
  sequence wr_at(logic [7:0] a);
    psel_in && penable_in && pready_out && pwrite_in && paddr_in == a;
  endsequence
  // completed read of any register
  sequence rd_done;
    psel_in && penable_in && pready_out && !pwrite_in;
  endsequence
  // ****************
  // assertions
  // ****************
  chk_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("pready missing after setup");
  chk_range_upper: assert property (
    rd_done ##0 (paddr_in == touch_sense_pkg::addr_osc_range_ctrl) |-> prdata_out[31:2] == 30'h0)
    else $error("range register upper bits not zero");
  chk_read_byte: assert property (rd_done |-> prdata_out[31:8] == 24'h0)
    else $error("read data wider than a byte");
  chk_range_drive: assert property (
    wr_at(touch_sense_pkg::addr_osc_range_ctrl) |-> ##2
    osc_ctrl_out.range_sel == $past(pwdata_in[1:0], 2))
    else $error("range code not driven");
  chk_trim_drive: assert property (
    wr_at(touch_sense_pkg::addr_ref_cap_trim_low) |-> ##2
    osc_ctrl_out.cap_trim[7:0] == $past(pwdata_in[7:0], 2))
    else $error("trim low byte not driven");
  chk_mux_drive: assert property (
    wr_at(touch_sense_pkg::addr_sense_osc_ctrl) |-> ##2
    {osc_ctrl_out.key_sel, osc_ctrl_out.dbl_en, osc_ctrl_out.hop_hw} ==
    {$past(pwdata_in[6], 2), $past(pwdata_in[5], 2), $past(pwdata_in[3], 2)})
    else $error("oscillator control bits not driven");
  chk_hop_forced: assert property (osc_ctrl_out.hop_hw |-> osc_ctrl_out.hop_code == 3'h0)
    else $error("software hop code leaks under hardware hopping");
  chk_irq_pulse: assert property (touch_irq_request_out |=> !touch_irq_request_out)
    else $error("irq request longer than one cycle");
  chk_irq_cause: assert property (touch_irq_request_out |-> $past(slot_overflow_in))
    else $error("irq request without slot overflow");
  chk_irq_osc_off: assert property (
    touch_irq_request_out |-> ##[0:2] !osc_ctrl_out.osc_en)
    else $error("oscillators still on after slot overflow");
  chk_unmapped_err: assert property (
    rd_done ##0 (paddr_in > touch_sense_pkg::addr_measure_ctrl) |-> pslverr_out)
    else $error("unmapped read without error");
endmodule

bind touch_sense_count_regs touch_sense_count_regs_checker i_touch_sense_count_regs_checker (.*);

// ---- dv/touch_osc_model.sv ----
// model of the two key sense oscillators facing the core
`timescale 1ns/1ps
module touch_osc_model #(
  parameter int half_one_ns = 20,
  parameter int half_two_ns = 50
) (
  input wire logic osc_en_in,
  output logic sense_one_out,
  output logic sense_two_out
);
  // ****************
  // oscillators
  // ****************
  // run only while enabled; a stopped oscillator rests low, never frozen high
  initial sense_one_out = 1'b0;
  initial sense_two_out = 1'b0;
  always #(half_one_ns) sense_one_out = osc_en_in ? !sense_one_out : 1'b0;
  always #(half_two_ns) sense_two_out = osc_en_in ? !sense_two_out : 1'b0;
endmodule

// ---- dv/test_touch_sense_count_regs.sv ----
// self-checking bench for the touch sense measurement core
`timescale 1ns/1ps
module test_touch_sense_count_regs;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, s_one, s_two, irq, rd_err;
  logic slot_ovf = 1'b0;
  logic [31:0] rd;
  touch_sense_pkg::osc_ctrl_t osc;
  int n_errors = 0;
  int cmp_count = 0;
  int irq_seen = 0;
  always #5 ref_clk_in = !ref_clk_in;
  // sampled away from the edge so the pulse is settled
  always @(negedge ref_clk_in) if (irq === 1'b1) irq_seen++;
  touch_sense_count_regs i_touch_sense_count_regs (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .sense_input_one_in(s_one), .sense_input_two_in(s_two),
    .slot_overflow_in(slot_ovf), .osc_ctrl_out(osc), .touch_irq_request_out(irq));
  touch_osc_model i_touch_osc_model (.osc_en_in(osc.osc_en), .sense_one_out(s_one),
    .sense_two_out(s_two));
  // ****************
  // bus and compare tasks
  // ****************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    do @(posedge ref_clk_in); while (pready !== 1'b1);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_in(input string name, input int lo, input int hi, input logic [31:0] got);
    cmp_count++;
    if ($isunknown(got) || !(got >= lo && got <= hi)) begin
      n_errors++;
      $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, exp, rd);
  endtask
  // high byte then low byte; the low byte sits one word above
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    apb(1'b0, a, 32'h0);
    v[15:8] = rd[7:0];
    apb(1'b0, a + 8'h04, 32'h0);
    v[7:0] = rd[7:0];
  endtask
  task automatic final_report;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    check("range out", 32'h3, {30'h0, osc.range_sel});
    rd_chk("range", touch_sense_pkg::addr_osc_range_ctrl, 32'h3);
    for (logic [7:0] a = touch_sense_pkg::addr_function_count_high;
         a <= touch_sense_pkg::addr_sense_osc_ctrl; a += 8'h04) begin
      rd_chk("reset byte", a, 32'h0);
    end
  endtask
  task automatic t_ctrl;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, touch_sense_pkg::addr_osc_range_ctrl, 32'hFC | i);
      rd_chk("range", touch_sense_pkg::addr_osc_range_ctrl, i);
      check("range out", i, osc.range_sel);
    end
    apb(1'b1, touch_sense_pkg::addr_ref_cap_trim_high, 32'hFF);
    apb(1'b1, touch_sense_pkg::addr_ref_cap_trim_low, 32'hA5);
    rd_chk("trim hi", touch_sense_pkg::addr_ref_cap_trim_high, 32'h3);
    check("trim out", 32'h3A5, osc.cap_trim);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, touch_sense_pkg::addr_sense_osc_ctrl, (i[0] ? 32'h60 : 32'h0) | i);
      // control outputs are registered once more behind the register bits
      repeat (2) @(posedge ref_clk_in);
      check("hop code", i, osc.hop_code);
      check("mux dbl", {2{i[0]}}, {osc.key_sel, osc.dbl_en});
    end
    apb(1'b1, touch_sense_pkg::addr_sense_osc_ctrl, 32'h0D);
    repeat (2) @(posedge ref_clk_in);
    check("hop hw", 32'h8, {osc.hop_hw, osc.hop_code});
    apb(1'b1, touch_sense_pkg::addr_sense_osc_ctrl, 32'h0);
  endtask
  task automatic t_measure(input logic [1:0] div, input logic mux, input int lo, input int hi);
    logic [15:0] v1;
    logic [15:0] v2;
    logic [15:0] v3;
    int n;
    n = irq_seen;
    apb(1'b1, touch_sense_pkg::addr_sense_osc_ctrl, mux ? 32'h40 : 32'h0);
    apb(1'b1, touch_sense_pkg::addr_measure_ctrl, 32'h20 | div);
    repeat (4) @(posedge ref_clk_in);
    check("osc on", 32'h1, osc.osc_en);
    repeat (76) @(posedge ref_clk_in);
    slot_ovf <= 1'b1;
    repeat (10) @(posedge ref_clk_in);
    check("osc off", 32'h0, osc.osc_en);
    check("irq", n + 1, irq_seen);
    rd16(touch_sense_pkg::addr_function_count_high, v1);
    check_in("func count", 70, 95, {16'h0, v1} << div);
    rd16(touch_sense_pkg::addr_sense_count_high, v2);
    check_in("sense count", lo, hi, v2);
    repeat (20) @(posedge ref_clk_in);
    rd16(touch_sense_pkg::addr_function_count_high, v3);
    check("func held", v1, v3);
    rd16(touch_sense_pkg::addr_sense_count_high, v3);
    check("sense held", v2, v3);
    apb(1'b0, touch_sense_pkg::addr_measure_ctrl, 32'h0);
    check("slot flag", 32'h1, rd[6]);
    apb(1'b1, touch_sense_pkg::addr_measure_ctrl, 32'h0);
    slot_ovf <= 1'b0;
    rd16(touch_sense_pkg::addr_function_count_high, v1);
    rd16(touch_sense_pkg::addr_sense_count_high, v2);
    check("cleared", 32'h0, {v1, v2});
  endtask
  task automatic t_misc;
    rd_chk("unmapped", 8'h24, 32'h0);
    check("slverr", 32'h1, rd_err);
    apb(1'b1, touch_sense_pkg::addr_function_count_low, 32'hFF);
    rd_chk("ro byte", touch_sense_pkg::addr_function_count_low, 32'h0);
    apb(1'b1, touch_sense_pkg::addr_measure_ctrl, 32'h20);
    repeat (65560) @(posedge ref_clk_in);
    apb(1'b0, touch_sense_pkg::addr_measure_ctrl, 32'h0);
    check("wrap flags", 32'h1, rd[4:3]);
    // a 1 written to a flag keeps it; only a 0 clears
    apb(1'b1, touch_sense_pkg::addr_measure_ctrl, 32'h28);
    rd_chk("flag sticky", touch_sense_pkg::addr_measure_ctrl, 32'h28);
    apb(1'b1, touch_sense_pkg::addr_measure_ctrl, 32'h0);
    rd_chk("flag clear", touch_sense_pkg::addr_measure_ctrl, 32'h0);
  endtask
  // ****************
  // main sequence and watchdog
  // ****************
  initial begin
    repeat (8) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    t_reset;
    t_ctrl;
    t_measure(2'h0, 1'b0, 16, 23);
    t_measure(2'h1, 1'b1, 6, 10);
    t_measure(2'h2, 1'b0, 16, 23);
    t_measure(2'h3, 1'b1, 6, 10);
    t_misc;
    final_report;
  end
  // a run of about 66k cycles; the limit at 90k cycles leaves headroom above it
  initial begin
    #900000;
    n_errors++;
    final_report;
  end
endmodule
